/* hw/lmx_pkg.sv */
// Package: register map, field layout, reset values and timing constants for the config bank
package lmx_pkg;

    // Register indices; the byte address on the bus is four times the index
    localparam logic [3:0] IDX_RUN_CTRL = 4'h1;  // Holds switching_run_enable
    localparam logic [3:0] IDX_GEN_CFG = 4'h2;   // general_config_clock_slew
    localparam logic [3:0] IDX_SHORT_TH = 4'h4;  // short_threshold_sw1_to_4
    localparam logic [3:0] IDX_STATUS = 4'h8;    // Block state readback
    localparam int ADDR_W = 6;                   // Byte address width
    localparam int DATA_W = 32;
    localparam int REG_W = 13;

    // Field positions in the first configuration register
    localparam int OPEN_TH_LSB = 7;
    localparam int SLOPE_LSB = 4;
    localparam int DIV_LSB = 2;
    localparam int CLK_SEL_LSB = 0;

    // Reset values of the fields
    localparam logic [1:0] OPEN_TH_RST = 2'h0;
    localparam logic [2:0] SLOPE_RST = 3'h7;
    localparam logic [1:0] DIV_RST = 2'h0;
    localparam logic [1:0] CLK_SEL_RST = 2'h0;
    localparam logic [2:0] SHORT_TH_RST = 3'h0;
    localparam int SHORT_TH_W = 3;
    localparam int NUM_SW = 4;

    // Dimming divider: shortest ratio 8,192 = 2^13, each code doubles it
    localparam int DIM_DIV_LOG2_BASE = 13;
    localparam int DIM_CNT_W = 16;

    // Clock source codes
    localparam logic [1:0] CLK_INT = 2'h0;
    localparam logic [1:0] CLK_INT_OUT = 2'h1;
    localparam logic [1:0] CLK_EXT = 2'h2;
    localparam logic [1:0] CLK_EXT_OUT = 2'h3;

    // Packed fields of the first configuration register
    typedef struct packed {
        logic [3:0] unused;
        logic [1:0] open_fault_threshold_sel;
        logic [2:0] gate_slope_sel;
        logic [1:0] dim_div_sel;
        logic [1:0] dim_clk_sel;
    } lmx_gen_cfg_t;

    // Packed thresholds of the second configuration register
    typedef struct packed {
        logic unused;
        logic [2:0] short_threshold_switch4;
        logic [2:0] short_threshold_switch3;
        logic [2:0] short_threshold_switch2;
        logic [2:0] short_threshold_switch1;
    } lmx_short_cfg_t;

    // Bus-side states
    typedef enum logic [0:0] {
        LMX_IDLE,
        LMX_DONE
    } lmx_bus_state_t;

endpackage : lmx_pkg

/* hw/lmx_dim_timer.sv */
// Dimming-period divider: one-cycle pulse every 2^(13+code) dimming clock ticks
`timescale 1ns/10ps
`default_nettype none
module lmx_dim_timer #(
    parameter int CNT_W = lmx_pkg::DIM_CNT_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic tick,
    input wire logic [1:0] div_sel,
    output logic period_pulse
);
    logic [CNT_W-1:0] cnt;        // Free count of dimming ticks
    logic [CNT_W-1:0] next_cnt;
    logic next_pulse;
    logic [CNT_W-1:0] last;       // Terminal value for the chosen ratio

    // Count ticks while running, hold at zero while stopped
    always_comb begin
        last = CNT_W'((32'h1 << (lmx_pkg::DIM_DIV_LOG2_BASE + int'(div_sel))) - 1);
        next_cnt = cnt;
        next_pulse = 1'b0;
        if (!run) begin
            next_cnt = '0;
        end else if (tick) begin
            if (cnt == last) begin
                next_cnt = '0;
                next_pulse = 1'b1;
            end else begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    // Register the counter and the pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= '0;
            period_pulse <= 1'b0;
        end else begin
            cnt <= next_cnt;
            period_pulse <= next_pulse;
        end
    end
endmodule : lmx_dim_timer
`default_nettype wire

/* hw/lmx_cfg_regs.sv */
// Top: general configuration registers of the LED bypass matrix over Avalon-MM
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
module lmx_cfg_regs (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [lmx_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [lmx_pkg::DATA_W-1:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [lmx_pkg::DATA_W-1:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic [1:0] AVS_RESPONSE,
    input wire logic EXTERNAL_DIM_CLOCK_INPUT,
    input wire logic INTERNAL_DIM_TICK,
    output logic DIM_CLOCK_OUTPUT,
    output logic SWITCHES_CLOSED,
    output logic DIM_PERIOD_PULSE,
    output logic [1:0] OPEN_FAULT_THRESHOLD_SEL,
    output logic [2:0] GATE_SLOPE_SEL,
    output logic [11:0] SHORT_THRESHOLD_CODES,
    output logic [7:0] SHORT_THRESHOLD_SWITCH1_DV,
    output logic WRITE_REFUSED
);
    lmx_pkg::lmx_gen_cfg_t gen_cfg;        // First configuration register
    lmx_pkg::lmx_gen_cfg_t next_gen_cfg;
    lmx_pkg::lmx_short_cfg_t short_cfg;    // Second configuration register
    lmx_pkg::lmx_short_cfg_t next_short_cfg;
    logic run_en;                          // switching_run_enable
    logic next_run_en;
    logic refused;                         // Sticky: a config write was dropped
    logic next_refused;
    lmx_pkg::lmx_bus_state_t state;
    lmx_pkg::lmx_bus_state_t next_state;
    logic [lmx_pkg::DATA_W-1:0] next_rdata;
    logic [1:0] next_resp;
    logic [3:0] idx;                       // Register index from byte address
    logic hit;                             // Address maps to a register
    logic ext_prev;                        // Previous external clock level
    logic next_ext_prev;
    logic dim_tick;                        // Selected dimming clock tick
    logic dim_pulse;
    logic clk_out;
    logic next_clk_out;
    logic [7:0] dv_lut [8];                // Short threshold in 0.1 V steps

    assign dv_lut = '{8'h0e, 8'h24, 8'h28, 8'h37, 8'h3c, 8'h42, 8'h48, 8'h4d};

    assign idx = AVS_ADDRESS[lmx_pkg::ADDR_W-1:2];
    assign hit = (idx == lmx_pkg::IDX_RUN_CTRL) || (idx == lmx_pkg::IDX_GEN_CFG) ||
                 (idx == lmx_pkg::IDX_SHORT_TH) || (idx == lmx_pkg::IDX_STATUS);

    // Bus state: accept in IDLE, answer with waitrequest low one cycle later
    always_comb begin
        next_state = state;
        next_gen_cfg = gen_cfg;
        next_short_cfg = short_cfg;
        next_run_en = run_en;
        next_refused = refused;
        next_rdata = AVS_READDATA;
        next_resp = AVS_RESPONSE;
        unique case (state)
            lmx_pkg::LMX_IDLE: begin
                if (AVS_READ || AVS_WRITE) begin
                    next_state = lmx_pkg::LMX_DONE;
                    next_rdata = '0;
                    next_resp = hit ? 2'h0 : 2'h3;
                    if (AVS_READ) begin
                        unique case (idx)
                            lmx_pkg::IDX_RUN_CTRL: next_rdata = {31'h0, run_en};
                            lmx_pkg::IDX_GEN_CFG: next_rdata = {19'h0, gen_cfg};
                            lmx_pkg::IDX_SHORT_TH: next_rdata = {19'h0, short_cfg};
                            lmx_pkg::IDX_STATUS: next_rdata = {30'h0, refused, run_en};
                            default: next_rdata = '0;
                        endcase
                    end else if (AVS_BYTEENABLE[0] || AVS_BYTEENABLE[1]) begin
                        unique case (idx)
                            lmx_pkg::IDX_RUN_CTRL: begin
                                if (AVS_BYTEENABLE[0]) begin
                                    next_run_en = AVS_WRITEDATA[0];
                                end
                            end
                            lmx_pkg::IDX_GEN_CFG: begin
                                if (run_en) begin
                                    next_refused = 1'b1;
                                end else begin
                                    next_gen_cfg = merge(gen_cfg, AVS_WRITEDATA[12:0]);
                                    next_gen_cfg.unused = '0;
                                end
                            end
                            lmx_pkg::IDX_SHORT_TH: begin
                                if (run_en) begin
                                    next_refused = 1'b1;
                                end else begin
                                    next_short_cfg = merge(short_cfg, AVS_WRITEDATA[12:0]);
                                    next_short_cfg.unused = 1'b0;
                                end
                            end
                            lmx_pkg::IDX_STATUS: begin
                                // Writing one to bit 1 clears the refused flag
                                if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[1]) begin
                                    next_refused = 1'b0;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            lmx_pkg::LMX_DONE: begin
                next_state = lmx_pkg::LMX_IDLE;
            end
        endcase
    end

    // Byte-lane merge of the 13-bit word
    function automatic logic [12:0] merge(input logic [12:0] old, input logic [12:0] wd);
        logic [12:0] res;
        res = old;
        if (AVS_BYTEENABLE[0]) begin
            res[7:0] = wd[7:0];
        end
        if (AVS_BYTEENABLE[1]) begin
            res[12:8] = wd[12:8];
        end
        return res;
    endfunction : merge

    // Register file and bus answer
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= lmx_pkg::LMX_IDLE;
            gen_cfg <= {4'h0, lmx_pkg::OPEN_TH_RST, lmx_pkg::SLOPE_RST,
                        lmx_pkg::DIV_RST, lmx_pkg::CLK_SEL_RST};
            short_cfg <= {1'b0, {lmx_pkg::NUM_SW{lmx_pkg::SHORT_TH_RST}}};
            run_en <= 1'b0;
            refused <= 1'b0;
            AVS_READDATA <= '0;
            AVS_RESPONSE <= 2'h0;
        end else begin
            state <= next_state;
            gen_cfg <= next_gen_cfg;
            short_cfg <= next_short_cfg;
            run_en <= next_run_en;
            refused <= next_refused;
            AVS_READDATA <= next_rdata;
            AVS_RESPONSE <= next_resp;
        end
    end

    // Waitrequest low only in the answer cycle; high at rest so no request slips by
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !(next_state == lmx_pkg::LMX_DONE);
        end
    end

    // Dimming clock select: external pin rising edges or internal tick
    always_comb begin
        next_ext_prev = EXTERNAL_DIM_CLOCK_INPUT;
        dim_tick = gen_cfg.dim_clk_sel[1] ? (EXTERNAL_DIM_CLOCK_INPUT && !ext_prev)
                                          : INTERNAL_DIM_TICK;
        // bit 0 enables the pin output: external clock level, or a toggle on each internal tick
        next_clk_out = gen_cfg.dim_clk_sel[0] ?
                       (gen_cfg.dim_clk_sel[1] ? EXTERNAL_DIM_CLOCK_INPUT
                                               : (clk_out ^ INTERNAL_DIM_TICK)) : 1'b0;
    end

    // Pin sampling and clock output
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            ext_prev <= 1'b0;
            clk_out <= 1'b0;
        end else begin
            ext_prev <= next_ext_prev;
            clk_out <= next_clk_out;
        end
    end

    // Dimming period divider
    lmx_dim_timer #(
        .CNT_W(lmx_pkg::DIM_CNT_W)
    ) u_timer (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .run(run_en),
        .tick(dim_tick),
        .div_sel(gen_cfg.dim_div_sel),
        .period_pulse(dim_pulse)
    );

    // Registered outputs to the analog side
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            DIM_CLOCK_OUTPUT <= 1'b0;
            SWITCHES_CLOSED <= 1'b1;
            DIM_PERIOD_PULSE <= 1'b0;
            OPEN_FAULT_THRESHOLD_SEL <= lmx_pkg::OPEN_TH_RST;
            GATE_SLOPE_SEL <= lmx_pkg::SLOPE_RST;
            SHORT_THRESHOLD_CODES <= '0;
            SHORT_THRESHOLD_SWITCH1_DV <= 8'h0e;
            WRITE_REFUSED <= 1'b0;
        end else begin
            DIM_CLOCK_OUTPUT <= clk_out;
            SWITCHES_CLOSED <= !run_en;
            DIM_PERIOD_PULSE <= dim_pulse;
            OPEN_FAULT_THRESHOLD_SEL <= gen_cfg.open_fault_threshold_sel;
            GATE_SLOPE_SEL <= gen_cfg.gate_slope_sel;
            SHORT_THRESHOLD_CODES <= short_cfg[11:0];
            SHORT_THRESHOLD_SWITCH1_DV <= dv_lut[short_cfg.short_threshold_switch1];
            WRITE_REFUSED <= refused;
        end
    end
endmodule : lmx_cfg_regs
`default_nettype wire

/* tb/lmx_cfg_regs_assertions.sv */
// Checker: bus timing and field update properties of the config bank
`timescale 1ns/10ps
`default_nettype none
module lmx_chk (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic [lmx_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [lmx_pkg::DATA_W-1:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic [1:0] AVS_RESPONSE,
    input wire logic SWITCHES_CLOSED,
    input wire logic DIM_PERIOD_PULSE,
    input wire logic [2:0] GATE_SLOPE_SEL,
    input wire logic [11:0] SHORT_THRESHOLD_CODES,
    input wire logic [7:0] SHORT_THRESHOLD_SWITCH1_DV,
    input wire logic WRITE_REFUSED
);
    // Switch 1 threshold in tenths of a volt, by code
    localparam logic [7:0] DV_LUT [8] = '{8'h0e, 8'h24, 8'h28, 8'h37, 8'h3c, 8'h42, 8'h48, 8'h4d};
    wire logic [3:0] idx = AVS_ADDRESS[5:2];
    // Answer cycle of any access
    wire logic ack = !AVS_WAITREQUEST && (AVS_READ || AVS_WRITE);
    wire logic cfg = (idx == lmx_pkg::IDX_GEN_CFG) || (idx == lmx_pkg::IDX_SHORT_TH);
    wire logic mapped = cfg || (idx == lmx_pkg::IDX_RUN_CTRL) || (idx == lmx_pkg::IDX_STATUS);
    // Config writes only count while switches are held closed
    wire logic gen_ok = ack && AVS_WRITE && idx == lmx_pkg::IDX_GEN_CFG && SWITCHES_CLOSED;
    wire logic sh_ok = ack && AVS_WRITE && idx == lmx_pkg::IDX_SHORT_TH && SWITCHES_CLOSED;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);
    // Request taken, then answered one cycle later
    sequence s_taken;
        $rose(AVS_READ || AVS_WRITE) ##1 !AVS_WAITREQUEST;
    endsequence
    // Config write arriving while running
    sequence s_run_cfg_wr;
        ack && AVS_WRITE && cfg && !SWITCHES_CLOSED;
    endsequence
    AST_WAIT_ONE: assert property ($rose(AVS_READ || AVS_WRITE) |-> s_taken)
        else $error("answer not one cycle after request");
    AST_WAIT_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low for more than one cycle");
    AST_UNMAPPED: assert property (ack && !mapped |-> AVS_RESPONSE == 2'h3)
        else $error("unmapped access not flagged");
    AST_MAPPED_OK: assert property (ack && mapped |-> AVS_RESPONSE == 2'h0)
        else $error("mapped access not answered ok");
    AST_SLOPE_SRC: assert property ($changed(GATE_SLOPE_SEL) |-> $past(gen_ok))
        else $error("slope changed without accepted write");
    AST_SHORT_SRC: assert property ($changed(SHORT_THRESHOLD_CODES) |-> $past(sh_ok))
        else $error("short codes changed without accepted write");
    AST_DV_MAP: assert property ($stable(SHORT_THRESHOLD_CODES[2:0]) [*3] |->
        SHORT_THRESHOLD_SWITCH1_DV == DV_LUT[SHORT_THRESHOLD_CODES[2:0]])
        else $error("switch 1 threshold value wrong");
    AST_PULSE_ONE: assert property (DIM_PERIOD_PULSE |=> !DIM_PERIOD_PULSE)
        else $error("period pulse longer than one cycle");
    AST_HELD: assert property (SWITCHES_CLOSED && $past(SWITCHES_CLOSED) |-> !DIM_PERIOD_PULSE)
        else $error("period pulse while stopped");
    AST_REFUSED: assert property (s_run_cfg_wr |-> ##2 WRITE_REFUSED)
        else $error("running config write not flagged");
endmodule : lmx_chk
bind lmx_cfg_regs lmx_chk i_lmx_chk (.CLOCK, .RESET_N, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_READDATA, .AVS_WAITREQUEST, .AVS_RESPONSE, .SWITCHES_CLOSED, .DIM_PERIOD_PULSE,
    .GATE_SLOPE_SEL, .SHORT_THRESHOLD_CODES, .SHORT_THRESHOLD_SWITCH1_DV, .WRITE_REFUSED);
`default_nettype wire

/* tb/tb_top.sv */
// Testbench: register access, refusal and dimming checks of the config bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic CLOCK, RESET_N, AVS_READ, AVS_WRITE, EXT, TICK;
    logic [5:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, rdata;
    logic [1:0] resp;
    wire logic [31:0] AVS_READDATA;
    wire logic AVS_WAITREQUEST, CLKO, CLOSED, PULSE, REFUSED;
    wire logic [1:0] AVS_RESPONSE, OPEN_TH;
    wire logic [2:0] SLOPE;
    wire logic [11:0] CODES;
    wire logic [7:0] DV;
    int fail_count = 0;
    int checks = 0;
    // Expected switch 1 threshold in tenths of a volt
    logic [7:0] dv_lut [8] = '{8'h0e, 8'h24, 8'h28, 8'h37, 8'h3c, 8'h42, 8'h48, 8'h4d};
    lmx_cfg_regs i_lmx_cfg_regs (.CLOCK(CLOCK), .RESET_N(RESET_N), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_BYTEENABLE(4'hf), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .AVS_RESPONSE(AVS_RESPONSE), .EXTERNAL_DIM_CLOCK_INPUT(EXT), .INTERNAL_DIM_TICK(TICK),
        .DIM_CLOCK_OUTPUT(CLKO), .SWITCHES_CLOSED(CLOSED), .DIM_PERIOD_PULSE(PULSE),
        .OPEN_FAULT_THRESHOLD_SEL(OPEN_TH), .GATE_SLOPE_SEL(SLOPE), .SHORT_THRESHOLD_CODES(CODES),
        .SHORT_THRESHOLD_SWITCH1_DV(DV), .WRITE_REFUSED(REFUSED));
    initial begin
        CLOCK = 1'b0;
        forever #2 CLOCK = ~CLOCK;
    end
    task automatic results;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= wr;
        AVS_READ <= !wr;
        do begin
            @(posedge CLOCK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 50);
        if (n >= 50) begin
            fail_count++;
            results();
        end
        rdata = AVS_READDATA;
        resp = AVS_RESPONSE;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
    endtask : bus
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdata, exp);
        chk(resp, 2'h0);
    endtask : rd
    task automatic t_reset;
        rd(6'h08, 32'h70);
        rd(6'h10, 32'h0);
        chk({CLOSED, SLOPE, OPEN_TH, DV}, {1'b1, 3'h7, 2'h0, 8'h0e});
        chk({CLKO, PULSE, REFUSED}, 3'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_gen;
        logic [31:0] d;
        for (int i = 0; i < 4; i++) begin
            d = 32'h1e00 | (i << 7) | ((6 - i) << 4) | (i << 2) | i;
            // run enable stays low for these writes
            bus(1'b1, 6'h08, d);
            rd(6'h08, d & 32'h1ff);
            chk({OPEN_TH, SLOPE}, {i[1:0], 3'(6 - i)});
        end
        $display("test general config done");
    endtask : t_gen
    task automatic t_short;
        logic [31:0] d;
        for (int c = 0; c < 8; c++) begin
            d = 32'h1000 | (c << 9) | ((7 - c) << 6) | (c << 3) | c;
            bus(1'b1, 6'h10, d);
            rd(6'h10, d & 32'hfff);
            repeat (3) @(posedge CLOCK);
            chk({CODES, DV}, {d[11:0], dv_lut[c]});
        end
        $display("test short codes done");
    endtask : t_short
    task automatic t_run;
        bus(1'b1, 6'h04, 32'h1);
        rd(6'h20, 32'h1);
        chk(CLOSED, 1'b0);
        bus(1'b1, 6'h08, 32'h70);
        bus(1'b1, 6'h10, 32'h0);
        rd(6'h08, 32'h1bf);
        rd(6'h10, 32'he3f);
        rd(6'h20, 32'h3);
        chk(REFUSED, 1'b1);
        bus(1'b1, 6'h04, 32'h0);
        bus(1'b1, 6'h20, 32'h2);
        rd(6'h20, 32'h0);
        chk(REFUSED, 1'b0);
        bus(1'b0, 6'h0c, 32'h0);
        chk(resp, 2'h3);
        chk(rdata, 32'h0);
        $display("test run refusal done");
    endtask : t_run
    task automatic t_dim;
        int n;
        logic prev;
        // run enable is low for every config write here
        bus(1'b1, 6'h08, 32'h3);
        EXT <= 1'b1;
        repeat (4) @(posedge CLOCK);
        chk(CLKO, 1'b1);
        bus(1'b1, 6'h08, 32'h2);
        repeat (4) @(posedge CLOCK);
        chk(CLKO, 1'b0);
        EXT <= 1'b0;
        bus(1'b1, 6'h08, 32'h0);
        repeat (4) @(posedge CLOCK);
        chk(CLKO, 1'b0);
        TICK <= 1'b1;
        bus(1'b1, 6'h08, 32'h1);
        repeat (4) @(posedge CLOCK);
        prev = CLKO;
        @(posedge CLOCK);
        chk(CLKO, !prev);
        bus(1'b1, 6'h04, 32'h1);
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PULSE !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            fail_count++;
            results();
        end
        // Restart from zero: 8192 ticks plus one register stage
        chk(n, 8193);
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PULSE !== 1'b1 && n < 20000);
        chk(n, 8192);
        bus(1'b1, 6'h04, 32'h0);
        $display("test dimming done");
    endtask : t_dim
    initial begin
        RESET_N = 1'b0;
        {AVS_READ, AVS_WRITE, EXT, TICK} = 4'h0;
        AVS_ADDRESS = 6'h00;
        AVS_WRITEDATA = 32'h0;
        repeat (5) @(posedge CLOCK);
        RESET_N <= 1'b1;
        t_reset();
        t_gen();
        t_short();
        t_run();
        t_dim();
        results();
    end
endmodule : tb_top
`default_nettype wire
